// ---- src/tpbu_defines.vh ----
// Register offsets, field positions, reset values and codes of the timer unit.
`ifndef TPBU_DEFINES_VH
`define TPBU_DEFINES_VH
`define TPBU_OFS_CTL1 8'h00
`define TPBU_OFS_CTL2 8'h04
`define TPBU_OFS_UPPER 8'h08
`define TPBU_OFS_TLOW 8'h0c
`define TPBU_OFS_DUTY 8'h10
`define TPBU_OFS_PRE 8'h14
`define TPBU_OFS_IRQ2 8'h18
`define TPBU_OFS_TONE 8'h1c
`define TPBU_OFS_GIE 8'h20
`define TPBU_B_RUN 0
`define TPBU_B_RELOAD 1
`define TPBU_B_SHOT 2
`define TPBU_B_PWM_AL 6
`define TPBU_B_PWM_EN 7
`define TPBU_B_CS 5
`define TPBU_B_CE 4
`define TPBU_B_PSEN_N 3
`define TPBU_B_FLAG 4
`define TPBU_B_IE 0
`define TPBU_B_TONE_EN 7
`define TPBU_B_TONE_SRC 3
`define TPBU_B_GIE 0
`define TPBU_RST_CTL1 8'h00
`define TPBU_RST_CTL2 8'h08
`define TPBU_RST_CNT 10'h3ff
`define TPBU_FREE_RUN 10'h3ff
`define TPBU_RESP_OKAY 2'b00
`define TPBU_RESP_SLVERR 2'b10
`endif

// ---- src/tpbu_timer.v ----
// Timer, PWM and tone generator with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "tpbu_defines.vh"
module tpbu_timer (
  input wire clk,
  input wire arst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire external_count_pin,
  output reg shared_output_pin_o,
  output reg shared_output_pin_oe_n,
  output reg irq_req
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [7:0] ctl1_r;
  reg [7:0] ctl2_r;
  reg [7:0] upper_r;
  reg [7:0] tlow_r;
  reg [7:0] duty_low_r;
  reg flag_r;
  reg ie_r;
  reg [7:0] tone_ctl_r;
  reg gie_r;
  reg [9:0] cnt_r;
  reg [9:0] duty_act_r;
  reg [9:0] pwm_pos_r;
  reg [7:0] pre_r;
  reg [7:0] tone_div_r;
  reg tone_r;
  reg ext_prev_r;
  reg [7:0] aw_addr_r;
  reg aw_got_r;
  reg [7:0] w_data_r;
  reg w_lane0_r;
  reg w_got_r;
  reg [31:0] rd_nxt;
  reg rd_err_nxt;

  wire wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire wr_map = (aw_addr_r[1:0] == 2'b00) && (aw_addr_r <= `TPBU_OFS_GIE);
  wire wr_en = wr_fire & wr_map & w_lane0_r;
  wire wr_ctl1 = wr_en && aw_addr_r == `TPBU_OFS_CTL1;
  wire wr_ctl2 = wr_en && aw_addr_r == `TPBU_OFS_CTL2;
  wire wr_upper = wr_en && aw_addr_r == `TPBU_OFS_UPPER;
  wire wr_tlow = wr_en && aw_addr_r == `TPBU_OFS_TLOW;
  wire wr_duty = wr_en && aw_addr_r == `TPBU_OFS_DUTY;
  wire wr_irq2 = wr_en && aw_addr_r == `TPBU_OFS_IRQ2;
  wire wr_tone = wr_en && aw_addr_r == `TPBU_OFS_TONE;
  wire wr_gie = wr_en && aw_addr_r == `TPBU_OFS_GIE;

  wire running = ctl1_r[`TPBU_B_RUN];
  wire [9:0] reload_buf = {upper_r[5:4], tlow_r};
  wire [9:0] duty_buf = {upper_r[1:0], duty_low_r};

  // ----------------------------------------
  // Clock source and prescaler
  // ----------------------------------------
  // edge choice
  wire ext_edge = ctl2_r[`TPBU_B_CE] ? (ext_prev_r & ~external_count_pin)
                                     : (~ext_prev_r & external_count_pin);
  wire src_tick = running & (ctl2_r[`TPBU_B_CS] ? ext_edge : 1'b1);
  // ratio mask, 1:2 at select 0 up to 1:256 at select 7
  wire [7:0] pre_mask = ~(8'hfe << ctl2_r[2:0]);
  wire pre_en = ~ctl2_r[`TPBU_B_PSEN_N];
  wire pre_tick = src_tick & ((pre_r & pre_mask) == pre_mask);
  wire tmr_tick = pre_en ? pre_tick : src_tick;
  wire underflow = tmr_tick & (cnt_r == 10'h000);

  // ----------------------------------------
  // Tone divider
  // ----------------------------------------
  // tone source
  wire tone_src = tone_ctl_r[`TPBU_B_TONE_SRC] ? underflow : tmr_tick;
  wire [7:0] tone_mask = ~(8'hff << tone_ctl_r[2:0]);
  wire tone_term = tone_src & ((tone_div_r & tone_mask) == tone_mask);

  // ----------------------------------------
  // PWM level
  // ----------------------------------------
  // active while the frame position is below the duty
  wire pwm_active = pwm_pos_r < duty_act_r;
  wire pwm_level = pwm_active ^ ctl1_r[`TPBU_B_PWM_AL];

  // ----------------------------------------
  // Software control registers
  // ----------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl1_r <= `TPBU_RST_CTL1;
      ctl2_r <= `TPBU_RST_CTL2;
      upper_r <= 8'h00;
      tlow_r <= 8'h00;
      duty_low_r <= 8'h00;
      ie_r <= 1'b0;
      tone_ctl_r <= 8'h00;
      gie_r <= 1'b0;
    end
    else
    begin
      if (wr_ctl2)
        ctl2_r <= {2'b00, w_data_r[5:0]};
      if (wr_upper)
        upper_r <= {2'b00, w_data_r[5:4], 2'b00, w_data_r[1:0]};
      if (wr_tlow)
        tlow_r <= w_data_r;
      if (wr_duty)
        duty_low_r <= w_data_r;
      if (wr_tone)
        tone_ctl_r <= {w_data_r[7], 3'b000, w_data_r[3:0]};
      if (wr_gie)
        gie_r <= w_data_r[`TPBU_B_GIE];
      if (wr_irq2)
        ie_r <= w_data_r[`TPBU_B_IE];
      if (wr_ctl1)
        ctl1_r <= {w_data_r[7:6], 3'b000, w_data_r[2:0]};
      // single shot stops itself at underflow
      else if (underflow && ctl1_r[`TPBU_B_SHOT])
        ctl1_r <= {ctl1_r[7:1], 1'b0};
    end
  end

  // ----------------------------------------
  // Underflow flag and interrupt request
  // ----------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flag_r <= 1'b0;
      irq_req <= 1'b0;
    end
    else
    begin
      // set on underflow, and the set beats a same-cycle clear
      if (underflow)
        flag_r <= 1'b1;
      // only a software zero clears it
      else if (wr_irq2 && !w_data_r[`TPBU_B_FLAG])
        flag_r <= 1'b0;
      irq_req <= flag_r & ie_r & gie_r;
    end
  end

  // ----------------------------------------
  // Prescaler and down counter
  // ----------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_prev_r <= 1'b0;
      pre_r <= 8'h00;
      cnt_r <= `TPBU_RST_CNT;
    end
    else
    begin
      ext_prev_r <= external_count_pin;
      if (src_tick && pre_en)
        pre_r <= pre_r + 8'h01;
      // stopped timer loads at once on the low byte write
      if (wr_tlow && !running)
        cnt_r <= {upper_r[5:4], w_data_r};
      else if (underflow)
      begin
        if (ctl1_r[`TPBU_B_SHOT])
          cnt_r <= 10'h000;
        else if (ctl1_r[`TPBU_B_RELOAD])
          cnt_r <= reload_buf;
        else
          cnt_r <= `TPBU_FREE_RUN;
      end
      else if (tmr_tick)
        cnt_r <= cnt_r - 10'h001;
    end
  end

  // ----------------------------------------
  // PWM frame position
  // ----------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      duty_act_r <= 10'h000;
      pwm_pos_r <= 10'h000;
    end
    else
    begin
      if (underflow)
      begin
        // duty taken over at underflow only
        duty_act_r <= duty_buf;
        pwm_pos_r <= 10'h000;
      end
      else if (tmr_tick && pwm_pos_r != 10'h3ff)
        pwm_pos_r <= pwm_pos_r + 10'h001;
    end
  end

  // ----------------------------------------
  // Tone square wave
  // ----------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tone_div_r <= 8'h00;
      tone_r <= 1'b0;
    end
    else
    begin
      if (tone_src)
        tone_div_r <= tone_div_r + 8'h01;
      if (tone_term)
        tone_r <= ~tone_r;
    end
  end

  // ----------------------------------------
  // Shared pin drive
  // ----------------------------------------
  // Level and enable share one register stage, so the pin never turns on with a stale level.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shared_output_pin_o <= 1'b0;
      shared_output_pin_oe_n <= 1'b1;
    end
    else
    begin
      if (ctl1_r[`TPBU_B_PWM_EN])
        shared_output_pin_o <= pwm_level;
      else if (tone_ctl_r[`TPBU_B_TONE_EN])
        shared_output_pin_o <= tone_r;
      else
        shared_output_pin_o <= 1'b0;
      shared_output_pin_oe_n <= ~(ctl1_r[`TPBU_B_PWM_EN] | tone_ctl_r[`TPBU_B_TONE_EN]);
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    rd_err_nxt = 1'b0;
    case (s_axi_araddr)
      `TPBU_OFS_CTL1: rd_nxt[7:0] = ctl1_r;
      `TPBU_OFS_CTL2: rd_nxt[7:0] = ctl2_r;
      `TPBU_OFS_UPPER: rd_nxt[7:0] = upper_r;
      `TPBU_OFS_TLOW: rd_nxt[9:0] = cnt_r;
      `TPBU_OFS_DUTY: rd_nxt[7:0] = duty_low_r;
      `TPBU_OFS_PRE: rd_nxt[7:0] = pre_r;
      `TPBU_OFS_IRQ2: rd_nxt[7:0] = {3'b000, flag_r, 3'b000, ie_r};
      `TPBU_OFS_TONE: rd_nxt[7:0] = tone_ctl_r;
      `TPBU_OFS_GIE: rd_nxt[0] = gie_r;
      default: rd_err_nxt = 1'b1;
    endcase
  end

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  // Address and data are caught separately so either may come first.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPBU_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `TPBU_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_addr_r <= 8'h00;
      aw_got_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
      w_got_r <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_got_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_r <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
        w_got_r <= 1'b1;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `TPBU_RESP_OKAY : `TPBU_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_nxt;
        s_axi_rresp <= rd_err_nxt ? `TPBU_RESP_SLVERR : `TPBU_RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // tpbu_timer

// ---- dv/tpbu_timer_checker.sv ----
// Concurrent checks on the register bus and shared pin of the timer unit.
`timescale 1ns/1ps
module tpbu_timer_checker (
  input logic clk,
  input logic arst_n,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic external_count_pin,
  input logic shared_output_pin_o,
  input logic shared_output_pin_oe_n,
  input logic irq_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted early");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted early");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  pin_idle_a: assert property (shared_output_pin_oe_n [*2] |-> !shared_output_pin_o)
    else $error("released pin not low");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(irq_req));
endmodule // tpbu_timer_checker
bind tpbu_timer tpbu_timer_checker u_chk (.*);

// ---- dv/tb_tpbu_timer.sv ----
// Self-checking bench for the timer unit driven over its register bus.
`timescale 1ns/1ps
module tb_tpbu_timer;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, external_count_pin = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic shared_output_pin_o, shared_output_pin_oe_n, irq_req;
  int bad_count = 0, samples_checked = 0, k, e;
  tpbu_timer DUT (.*);
  initial forever #20 clk = ~clk;
  task print_verdict;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task bound(input int n);
    if (n >= 50)
    begin
      bad_count++;
      print_verdict();
    end
  endtask
  // Bready is raised only after bvalid shows, so the slave must hold its answer.
  task wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    bound(n);
  endtask
  task rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    bound(n);
  endtask
  task ones(input int w, input int cyc);
    repeat (w) @(posedge clk);
    k = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      k += shared_output_pin_o;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h04);
    chk("ctl2 reset", v, 32'h08);
    rd(8'h0c);
    chk("count reset", v, 32'h3ff);
    rd(8'h24);
    chk("unmapped resp", {30'h0, r}, 32'h2);
    wr(8'h24, 8'hff);
    chk("unmapped write", {30'h0, r}, 32'h2);
    wr(8'h08, 8'h10);
    chk("write okay", {30'h0, r}, 32'h0);
    wr(8'h0c, 8'h05);
    rd(8'h0c);
    chk("stopped load", v, 32'h105);
    $display("test reset and load done");
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h04);
    wr(8'h00, 8'h05);
    repeat (20) @(posedge clk);
    rd(8'h00);
    chk("run cleared", v, 32'h04);
    rd(8'h0c);
    chk("shot end", v, 32'h0);
    repeat (20) @(posedge clk);
    rd(8'h18);
    chk("flag kept", v, 32'h10);
    wr(8'h20, 8'h01);
    wr(8'h18, 8'h11);
    repeat (2) @(posedge clk);
    chk("irq up", irq_req, 1'b1);
    wr(8'h18, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq down", irq_req, 1'b0);
    $display("test single shot done");
    wr(8'h00, 8'h03);
    wr(8'h1c, 8'h80);
    ones(10, 40);
    chk("tone tick", k, 20);
    chk("tone oe", shared_output_pin_oe_n, 1'b0);
    wr(8'h1c, 8'h88);
    ones(30, 40);
    chk("tone underflow", k, 20);
    for (e = 0; e < 3; e++)
    begin
      wr(8'h10, e == 2 ? 8'h00 : 8'h02);
      wr(8'h00, e == 1 ? 8'hc3 : 8'h83);
      ones(20, 50);
      chk("pwm ones", k, e == 0 ? 20 : e == 1 ? 30 : 0);
    end
    wr(8'h00, 8'h00);
    wr(8'h1c, 8'h00);
    $display("test tone and pwm done");
    for (e = 0; e < 2; e++)
    begin
      wr(8'h0c, 8'h10);
      wr(8'h04, e ? 8'h38 : 8'h28);
      wr(8'h00, 8'h01);
      repeat (3)
      begin
        repeat (2) @(posedge clk);
        external_count_pin <= 1'b1;
        repeat (2) @(posedge clk);
        external_count_pin <= 1'b0;
      end
      wr(8'h00, 8'h00);
      rd(8'h0c);
      chk("pin edges", v, 32'h0d);
    end
    chk("pin released", shared_output_pin_oe_n, 1'b1);
    wr(8'h0c, 8'h10);
    wr(8'h04, 8'h07);
    wr(8'h00, 8'h01);
    repeat (100) @(posedge clk);
    wr(8'h00, 8'h00);
    rd(8'h0c);
    chk("slow prescale", v, 32'h10);
    rd(8'h14);
    chk("prescale live", v, 32'h69);
    $display("test sources done");
    print_verdict();
  end
endmodule // tb_tpbu_timer
